// ===== logic/rsw_params.svh
`ifndef RSW_PARAMS_SVH
`define RSW_PARAMS_SVH

// Register byte offsets (low address byte only)
`define RSW_OFF_CTRL 8'h00
`define RSW_OFF_SRC 8'h04
`define RSW_OFF_OUT_DIV_SELECT 8'h08
`define RSW_OFF_STAT 8'h0c
// Post-divider of bank b sits at QBASE + 4*b, b = 1..5
`define RSW_OFF_QBASE 8'h20
`define RSW_QBASE_HI 3'h1

// Reset values
`define RSW_CTRL_RST 17'h00fe0
`define RSW_SRC_RST 12'hfff
`define RSW_OUT_DIV_SELECT_RST 12'h000
`define RSW_Q_RST 20'h00000

// Source code of the selected reference in a bank source field
`define RSW_SRC_REF 2'h3

// Timing counts
`define RSW_MISS_TICKS 2'h2
`define RSW_HOLD_EDGES 2'h2
`define RSW_REVERT_SHORT 11'h008
`define RSW_REVERT_LONG 11'h400

`endif

// ===== logic/rsw_pkg.sv
package rsw_pkg;

   typedef enum logic {ST_PRIM, ST_SEC} rsw_state_t;

   // Control register, bit 0 is switchover_mode[0]
   typedef struct packed {
      logic [4:0] post_div_power;
      logic [5:0] gp_input_enable;
      logic prog_mode;
      logic manual_freq_control;
      logic revert_threshold_sel;
      logic primary_source_sel;
      logic [1:0] switchover_mode;
   } rsw_ctrl_t;

endpackage

// ===== logic/rsw_watch.sv
`include "rsw_params.svh"

module rsw_watch
   import rsw_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sig,
   input wire logic tick,
   output logic missing
);

   logic prev_reg;
   logic [1:0] cnt_reg;
   logic missing_reg;

   wire trans = sig != prev_reg;
   wire at_limit = cnt_reg == `RSW_MISS_TICKS;

   // Any transition restarts the count, so only consecutive silence counts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_reg <= 1'b0;
         cnt_reg <= 2'h0;
         missing_reg <= 1'b0;
      end else begin
         prev_reg <= sig;
         if (trans) begin
            cnt_reg <= 2'h0;
            missing_reg <= 1'b0;
         end else if (tick && !at_limit) begin
            cnt_reg <= cnt_reg + 2'h1;
            missing_reg <= (cnt_reg + 2'h1) == `RSW_MISS_TICKS;
         end
      end
   end

   assign missing = missing_reg;

endmodule

// ===== logic/rsw_postdiv.sv
`include "rsw_params.svh"

module rsw_postdiv
   import rsw_pkg::*;
#(
   parameter int QW = 10
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic src,
   input wire logic en,
   input wire logic [QW-1:0] div,
   output logic out
);

   logic prev_reg;
   logic [QW-1:0] cnt_reg;
   logic out_reg;

   wire rise = src && !prev_reg;
   wire last = cnt_reg >= div - QW'(1);

   // Zero divide passes the source straight through
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_reg <= 1'b0;
         cnt_reg <= '0;
         out_reg <= 1'b0;
      end else begin
         prev_reg <= src;
         if (!en) begin
            cnt_reg <= '0;
            out_reg <= 1'b0;
         end else if (div == '0) begin
            out_reg <= src;
         end else if (rise) begin
            cnt_reg <= last ? '0 : cnt_reg + QW'(1);
            out_reg <= last ? !out_reg : out_reg;
         end
      end
   end

   assign out = out_reg;

endmodule

// ===== logic/rsw_ref_switch.sv
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`include "rsw_params.svh"

// How it works
// - Four-config mode: two inputs per PLL
// - Eight-config mode: three inputs pick PLL0 config
// - Active config bit picks post-divider setting
// - Latch five inputs at power-up, sixth low
// - Settings survive shutdown; only reset clears
// - Powered PLL out of lock flags lock-loss
// - Missing selected reference flags input-loss
// - Internal oscillator times missing-clock detection
// - Mode field: manual, auto non-revertive, revertive
// - Primary bit picks which input is primary
// - Manual mode: select pin switches, glitch free
// - Source change holds lock-loss two new cycles
// - Auto: primary silent two cycles, switch over
// - Both inputs dead flags both indicators
// - Non-revertive returns only on select toggle
// - Revertive returns after 8 or 1024 cycles
// - Stay on primary unless it goes missing
// - Each bank selects PLL or reference source
// - Defaults: only first bank toggles, from reference
// - Banks after first have two-setting post-divider
// - Live inputs when not programming, disabled read low
module rsw_ref_switch
   import rsw_pkg::*;
#(
   parameter int OSC_DIV = 25,
   parameter int NBANK = 6,
   parameter int QW = 10
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic crystal_ref_input,
   input wire logic second_clock_input,
   input wire logic gp_in_0,
   input wire logic gp_in_1,
   input wire logic gp_in_2,
   input wire logic gp_in_3,
   input wire logic gp_in_4,
   input wire logic gp_in_5,
   input wire logic [2:0] pll_clk,
   input wire logic [2:0] pll_locked,
   input wire logic [2:0] pll_powered,
   output logic [2:0] pll0_cfg,
   output logic [1:0] pll1_cfg,
   output logic [1:0] pll2_cfg,
   output logic lock_lost,
   output logic input_lost_flag,
   output logic ref_clk_out,
   output logic [NBANK-1:0] bank_out
);

   rsw_ctrl_t ctrl_reg;
   logic [11:0] src_reg, out_div_select_reg;
   logic [2*QW-1:0] q_reg [NBANK];
   logic ap_wr_reg, hreadyout_reg;
   logic [7:0] ap_addr_reg;
   logic [31:0] hrdata_reg;
   logic gp_latched_reg;
   logic [4:0] gp_latch_reg;
   logic [2:0] pll0_cfg_reg, pll_out_div_select_reg;
   logic [1:0] pll1_cfg_reg, pll2_cfg_reg;
   logic prim_prev_reg, sec_prev_reg, clk_sel_prev_reg;
   logic [7:0] osc_cnt_reg;
   rsw_state_t state_reg, state_next;
   logic [10:0] valid_cnt_reg;
   logic [1:0] hold_reg;
   logic relock_reg, lost_latch_reg, active_reg, ref_out_reg;
   logic lock_lost_reg, input_lost_reg;
   logic [3:0] wsig, wtick, wmiss;
   logic [NBANK-1:0] bank_q;

   // Bus side: registered read data gives a zero-wait answer
   wire ap_valid = hsel && hready && htrans[1];
   wire [7:0] ra = haddr[7:0];
   wire [2:0] q_idx = ra[4:2];
   wire q_hit = ra[7:5] == `RSW_QBASE_HI && q_idx != 3'h0 && int'(q_idx) < NBANK
      && ra[1:0] == 2'h0;
   wire [2:0] qw_idx = ap_addr_reg[4:2];
   wire qw_hit = ap_addr_reg[7:5] == `RSW_QBASE_HI && qw_idx != 3'h0
      && int'(qw_idx) < NBANK && ap_addr_reg[1:0] == 2'h0;
   wire wr_ctrl = ap_wr_reg && ap_addr_reg == `RSW_OFF_CTRL;
   wire wr_src = ap_wr_reg && ap_addr_reg == `RSW_OFF_SRC;
   wire wr_out_div_select = ap_wr_reg && ap_addr_reg == `RSW_OFF_OUT_DIV_SELECT;
   wire wr_q = ap_wr_reg && qw_hit;

   wire [31:0] stat_word = {17'h0, pll2_cfg_reg, pll1_cfg_reg, pll0_cfg_reg, pll_out_div_select_reg,
      wmiss[1], wmiss[0], state_reg == ST_SEC, input_lost_reg, lock_lost_reg};
   wire [31:0] rd_data = ra == `RSW_OFF_CTRL ? {15'h0, ctrl_reg}
      : ra == `RSW_OFF_SRC ? {20'h0, src_reg}
      : ra == `RSW_OFF_OUT_DIV_SELECT ? {20'h0, out_div_select_reg}
      : ra == `RSW_OFF_STAT ? stat_word
      : q_hit ? {6'h0, q_reg[q_idx][2*QW-1:QW], 6'h0, q_reg[q_idx][QW-1:0]}
      : 32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_reg <= 1'b0;
         ap_addr_reg <= 8'h00;
         hreadyout_reg <= 1'b1;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         ap_wr_reg <= ap_valid && hwrite;
         ap_addr_reg <= ra;
         hreadyout_reg <= 1'b1;
         hrdata_reg <= (ap_valid && !hwrite) ? rd_data : 32'h0000_0000;
      end
   end

   // No shutdown input touches these; only a power-on reset does
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= `RSW_CTRL_RST;
         src_reg <= `RSW_SRC_RST;
         out_div_select_reg <= `RSW_OUT_DIV_SELECT_RST;
      end else begin
         if (wr_ctrl) ctrl_reg <= hwdata[16:0];
         if (wr_src) src_reg <= hwdata[11:0];
         if (wr_out_div_select) out_div_select_reg <= hwdata[11:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NBANK; i++) q_reg[i] <= `RSW_Q_RST;
      end else if (wr_q) begin
         q_reg[qw_idx] <= {hwdata[QW+15:16], hwdata[QW-1:0]};
      end
   end

   // Configuration select
   wire [5:0] gp_raw = {gp_in_5, gp_in_4, gp_in_3, gp_in_2, gp_in_1, gp_in_0};
   wire [5:0] gp_live = gp_raw & ctrl_reg.gp_input_enable;
   wire [5:0] gp_eff = ctrl_reg.prog_mode ? {1'b0, gp_latch_reg} : gp_live;
   wire clk_sel = gp_live[5];
   wire [2:0] p0_idx = ctrl_reg.manual_freq_control ? gp_eff[2:0] : {1'b0, gp_eff[1:0]};
   wire [1:0] p1_idx = gp_eff[3:2];
   wire [1:0] p2_idx = gp_eff[5:4];
   // Slots 4..5 borrow PLL1 storage, 6..7 borrow PLL2 storage
   wire [3:0] p0_slot = p0_idx[2] ? {p0_idx[1], !p0_idx[1], 1'b0, p0_idx[0]}
      : {2'b00, p0_idx[1:0]};
   wire [2:0] pll_out_div_select = {out_div_select_reg[{2'b10, p2_idx}], out_div_select_reg[{2'b01, p1_idx}],
      out_div_select_reg[p0_slot]};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gp_latched_reg <= 1'b0;
         gp_latch_reg <= 5'h00;
      end else if (!gp_latched_reg) begin
         gp_latched_reg <= 1'b1;
         gp_latch_reg <= gp_raw[4:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll0_cfg_reg <= 3'h0;
         pll1_cfg_reg <= 2'h0;
         pll2_cfg_reg <= 2'h0;
         pll_out_div_select_reg <= 3'h0;
      end else begin
         pll0_cfg_reg <= p0_idx;
         pll1_cfg_reg <= p1_idx;
         pll2_cfg_reg <= p2_idx;
         pll_out_div_select_reg <= pll_out_div_select;
      end
   end

   // Reference switchover
   wire prim_lvl = ctrl_reg.primary_source_sel ? second_clock_input : crystal_ref_input;
   wire sec_lvl = ctrl_reg.primary_source_sel ? crystal_ref_input : second_clock_input;
   wire prim_rise = prim_lvl && !prim_prev_reg;
   wire sec_rise = sec_lvl && !sec_prev_reg;
   wire osc_tick = osc_cnt_reg == 8'(OSC_DIV - 1);
   wire auto_mode = ctrl_reg.switchover_mode[1];
   wire revertive = ctrl_reg.switchover_mode[0];
   wire sel_toggle = clk_sel != clk_sel_prev_reg;
   wire [10:0] revert_thr = ctrl_reg.revert_threshold_sel ? `RSW_REVERT_LONG
      : `RSW_REVERT_SHORT;

   // Watchers 0/1: each input timed by the other's edges; 2/3: by internal oscillator
   assign wsig = {sec_lvl, prim_lvl, sec_lvl, prim_lvl};
   assign wtick = {osc_tick, osc_tick, prim_rise, sec_rise};

   generate
      for (genvar w = 0; w < 4; w++) begin : g_watch
         rsw_watch u_watch (
            .hclk(hclk),
            .hresetn(hresetn),
            .sig(wsig[w]),
            .tick(wtick[w]),
            .missing(wmiss[w])
         );
      end
   endgenerate

   wire prim_gone = wmiss[0];
   wire both_dead = wmiss[2] && wmiss[3];
   wire sel_missing = state_reg == ST_SEC ? (wmiss[1] || wmiss[3])
      : (wmiss[0] || wmiss[2]);

   always_comb begin
      state_next = state_reg;
      if (!auto_mode) begin
         state_next = clk_sel ? ST_SEC : ST_PRIM;
      end else begin
         case (state_reg)
            ST_PRIM: if (prim_gone) state_next = ST_SEC;
            ST_SEC: begin
               if (revertive && valid_cnt_reg >= revert_thr) state_next = ST_PRIM;
               else if (!revertive && sel_toggle) state_next = ST_PRIM;
            end
            default: state_next = ST_PRIM;
         endcase
      end
   end

   wire switch_ev = state_next != state_reg;
   wire auto_ev = switch_ev && auto_mode && state_reg == ST_PRIM;
   wire sel_rise = state_reg == ST_SEC ? sec_rise : prim_rise;
   wire pll_bad = |(pll_powered & ~pll_locked);
   wire all_locked = !pll_bad;
   wire new_lvl = active_reg ? prim_lvl : sec_lvl;
   // Hand over only while both old and new are low: no runt pulse
   wire hand_over = active_reg != (state_reg == ST_SEC) && !ref_out_reg && !new_lvl;
   wire active_next = hand_over ? !active_reg : active_reg;
   wire [1:0] hold_next = switch_ev ? `RSW_HOLD_EDGES
      : (hold_reg != 2'h0 && sel_rise) ? hold_reg - 2'h1 : hold_reg;
   wire lock_next = pll_bad || hold_reg != 2'h0 || relock_reg || switch_ev || both_dead;
   wire input_next = sel_missing || both_dead || lost_latch_reg || auto_ev;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prim_prev_reg <= 1'b0;
         sec_prev_reg <= 1'b0;
         osc_cnt_reg <= 8'h00;
         clk_sel_prev_reg <= 1'b0;
         state_reg <= ST_PRIM;
      end else begin
         prim_prev_reg <= prim_lvl;
         sec_prev_reg <= sec_lvl;
         osc_cnt_reg <= osc_tick ? 8'h00 : osc_cnt_reg + 8'h01;
         clk_sel_prev_reg <= clk_sel;
         state_reg <= state_next;
      end
   end

   // Valid-primary count restarts whenever the primary goes quiet
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         valid_cnt_reg <= 11'h000;
      end else if (state_reg == ST_PRIM || prim_gone) begin
         valid_cnt_reg <= 11'h000;
      end else if (prim_rise && valid_cnt_reg != `RSW_REVERT_LONG) begin
         valid_cnt_reg <= valid_cnt_reg + 11'h001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_reg <= 2'h0;
         relock_reg <= 1'b0;
         lost_latch_reg <= 1'b0;
         active_reg <= 1'b0;
         ref_out_reg <= 1'b0;
         lock_lost_reg <= 1'b0;
         input_lost_reg <= 1'b0;
      end else begin
         hold_reg <= hold_next;
         // Lock-loss stays up until every powered PLL relocks
         if (auto_ev) relock_reg <= 1'b1;
         else if (hold_reg == 2'h0 && all_locked) relock_reg <= 1'b0;
         if (auto_ev) lost_latch_reg <= 1'b1;
         else if (state_reg == ST_PRIM) lost_latch_reg <= 1'b0;
         active_reg <= active_next;
         ref_out_reg <= active_next ? sec_lvl : prim_lvl;
         lock_lost_reg <= lock_next;
         input_lost_reg <= input_next;
      end
   end

   // Source matrix and post-dividers
   wire [3:0] mat_in = {ref_out_reg, pll_clk};

   generate
      for (genvar b = 0; b < NBANK; b++) begin : g_bank
         wire [1:0] src = src_reg[2*b+1:2*b];
         wire lvl = mat_in[src];
         if (b == 0) begin : g_first
            logic out_reg;
            always_ff @(posedge hclk or negedge hresetn) begin
               if (!hresetn) out_reg <= 1'b0;
               else out_reg <= lvl;
            end
            assign bank_q[b] = out_reg;
         end else begin : g_div
            wire od = src != `RSW_SRC_REF && pll_out_div_select_reg[src];
            rsw_postdiv #(.QW(QW)) u_div (
               .hclk(hclk),
               .hresetn(hresetn),
               .src(lvl),
               .en(ctrl_reg.post_div_power[b-1]),
               .div(od ? q_reg[b][2*QW-1:QW] : q_reg[b][QW-1:0]),
               .out(bank_q[b])
            );
         end
      end
   endgenerate

   assign bank_out = bank_q;
   assign hreadyout = hreadyout_reg;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign pll0_cfg = pll0_cfg_reg;
   assign pll1_cfg = pll1_cfg_reg;
   assign pll2_cfg = pll2_cfg_reg;
   assign lock_lost = lock_lost_reg;
   assign input_lost_flag = input_lost_reg;
   assign ref_clk_out = ref_out_reg;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   lock_pll_a: assert property (pll_bad |=> lock_lost)
      else $error("pll out of lock not flagged");
   input_sel_a: assert property (sel_missing |=> input_lost_flag)
      else $error("missing reference not flagged");
   hold_two_a: assert property (switch_ev |=> lock_lost [*2])
      else $error("lock-loss not held after switch");
   manual_sel_a: assert property (!auto_mode && $stable(ctrl_reg)
      |=> state_reg == ($past(clk_sel) ? ST_SEC : ST_PRIM))
      else $error("manual select not followed");
   auto_switch_a: assert property (auto_mode && state_reg == ST_PRIM && prim_gone
      |=> state_reg == ST_SEC && input_lost_flag && lock_lost)
      else $error("auto switchover missed");
   both_dead_a: assert property (both_dead |=> lock_lost && input_lost_flag)
      else $error("both inputs dead not flagged");
   nonrev_stay_a: assert property (ctrl_reg.switchover_mode == 2'b10 && state_reg == ST_SEC
      && !sel_toggle && $stable(ctrl_reg) |=> state_reg == ST_SEC)
      else $error("non-revertive returned on its own");
   revert_back_a: assert property (ctrl_reg.switchover_mode == 2'b11 && state_reg == ST_SEC
      && valid_cnt_reg >= revert_thr |=> state_reg == ST_PRIM)
      else $error("revertive return missed");
   cfg_disabled_a: assert property (!ctrl_reg.prog_mode && ctrl_reg.gp_input_enable == 6'h00
      && $stable(ctrl_reg) |=> pll0_cfg == 3'h0 && pll2_cfg == 2'h0)
      else $error("disabled inputs not read low");

   auto_sw_c: cover property (auto_ev);
   revert_c: cover property (state_reg == ST_SEC && revertive && state_next == ST_PRIM);
   manual_sw_c: cover property (!auto_mode && switch_ev ##[1:20] hand_over);
   both_dead_c: cover property (both_dead);

endmodule

// ===== verif/rsw_ref_src.sv
// Two redundant reference oscillators, stepped off hclk
module rsw_ref_src
#(
   parameter int HALF = 4
)
(
   input wire logic hclk,
   input wire logic run_a,
   input wire logic run_b,
   output logic clk_a,
   output logic clk_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ph = 8'h00;
   initial begin
      clk_a = 1'b0;
      clk_b = 1'b0;
   end
   // Both share one phase: in-phase sources are the hard case for switchover
   // A stopped source freezes at its last level, as a dead oscillator does
   always @(posedge hclk) begin
      ph <= (ph == 8'(HALF - 1)) ? 8'h00 : ph + 8'h01;
      if (ph == 8'h00 && run_a) clk_a <= ~clk_a;
      if (ph == 8'h00 && run_b) clk_b <= ~clk_b;
   end
endmodule

// ===== verif/rsw_ref_switch_tb.sv
module rsw_ref_switch_tb;
   import rsw_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans, pll1_cfg, pll2_cfg;
   logic [2:0] hsize, pll_clk, pll_locked, pll_powered, pll0_cfg;
   logic [5:0] gp, bank_out;
   logic lock_lost, input_lost_flag, ref_clk_out, run_a, run_b, xa, xb;
   logic [4:0] prv = 5'h00;
   int mismatches = 0;
   int comparisons = 0;
   int cyc = 0;
   int hi_run = 0;
   int cnt [5] = '{default: 0};
   int s [5];
   wire [4:0] sig = {xb, pll_clk[0], bank_out[2], bank_out[1], bank_out[0]};
   assign hready = hreadyout;
   assign pll_clk = {cyc[4], cyc[3], cyc[2]};

   rsw_ref_switch rsw_ref_switch_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .crystal_ref_input(xa), .second_clock_input(xb), .gp_in_0(gp[0]), .gp_in_1(gp[1]),
      .gp_in_2(gp[2]), .gp_in_3(gp[3]), .gp_in_4(gp[4]), .gp_in_5(gp[5]),
      .pll_clk(pll_clk), .pll_locked(pll_locked), .pll_powered(pll_powered),
      .pll0_cfg(pll0_cfg), .pll1_cfg(pll1_cfg), .pll2_cfg(pll2_cfg), .lock_lost(lock_lost),
      .input_lost_flag(input_lost_flag), .ref_clk_out(ref_clk_out), .bank_out(bank_out));

   rsw_ref_src rsw_ref_src_i (.hclk(hclk), .run_a(run_a), .run_b(run_b), .clk_a(xa),
      .clk_b(xb));

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task end_sim;
      $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Edge counters and glitch watch on the selected reference
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      prv <= sig;
      for (int i = 0; i < 5; i++) begin
         if (sig[i] && !prv[i] && (i != 4 || lock_lost)) cnt[i] <= cnt[i] + 1;
      end
      if (ref_clk_out === 1'b1) begin
         hi_run <= hi_run + 1;
      end else begin
         if (hi_run != 0) chk(32'(hi_run >= 3), 32'h1, "short ref pulse");
         hi_run <= 0;
      end
      if (cyc == 20000) begin
         mismatches++;
         $display("mismatch at %0t: timeout", $time);
         end_sim;
      end
   end

   // Single AHB transfer; hready is polled, never assumed
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task rdchk(input logic [31:0] a, input logic [31:0] exp, input string what);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask

   // Bounded poll of one status bit, then judge it
   task poll(input int b, input logic v, input int n, input string what);
      for (int i = 0; i < n; i++) begin
         xfer(1'b0, 32'h0000000c, 32'h0);
         if (rd[b] === v) break;
      end
      chk(32'(rd[b]), 32'(v), what);
   endtask

   function automatic int dlt(input int i);
      return cnt[i] - s[i];
   endfunction

   task t_defaults;
      rdchk(32'h00, 32'h00000fe0, "ctrl reset");
      rdchk(32'h04, 32'h00000fff, "src reset");
      rdchk(32'h08, 32'h0, "out_div_select reset");
      rdchk(32'h24, 32'h0, "q reset");
      rdchk(32'h40, 32'h0, "unmapped");
      chk(32'(hresp), 32'h0, "okay response");
      s = cnt;
      repeat (200) @(posedge hclk);
      chk(32'(dlt(0) >= 24 && dlt(0) <= 26), 32'h1, "bank0 rate");
      chk(32'(dlt(1) + dlt(2)), 32'h0, "other banks idle");
      chk(32'(bank_out[5:1]), 32'h0, "banks low");
      $display("done: defaults");
   endtask

   task t_config;
      gp <= 6'b011111;
      repeat (4) @(posedge hclk);
      chk(32'({pll0_cfg, pll1_cfg, pll2_cfg}), 32'h24, "latched cfg");
      xfer(1'b1, 32'h00, 32'h00000fc0);
      repeat (4) @(posedge hclk);
      chk(32'({pll0_cfg, pll1_cfg, pll2_cfg}), 32'h3d, "four cfg");
      xfer(1'b1, 32'h00, 32'h00000fd0);
      xfer(1'b1, 32'h08, 32'h00000200);
      repeat (4) @(posedge hclk);
      chk(32'(pll0_cfg), 32'h7, "eight cfg");
      poll(5, 1'b1, 1, "out_div_select of cfg 7");
      xfer(1'b1, 32'h00, 32'h00000ed0);
      repeat (4) @(posedge hclk);
      chk(32'(pll0_cfg), 32'h3, "disabled input low");
      xfer(1'b1, 32'h08, 32'h0);
      xfer(1'b1, 32'h00, 32'h0);
      repeat (4) @(posedge hclk);
      chk(32'({pll0_cfg, pll1_cfg, pll2_cfg}), 32'h0, "all inputs disabled");
      xfer(1'b1, 32'h00, 32'h00000fc0);
      gp <= 6'h00;
      $display("done: config");
   endtask

   task t_lock;
      pll_locked <= 3'b101;
      repeat (5) @(posedge hclk);
      chk(32'(lock_lost), 32'h1, "unlocked pll");
      pll_powered <= 3'b101;
      repeat (5) @(posedge hclk);
      chk(32'(lock_lost), 32'h0, "unpowered pll ignored");
      pll_locked <= 3'h7;
      pll_powered <= 3'h7;
      $display("done: lock");
   endtask

   task t_manual;
      s = cnt;
      gp[5] <= 1'b1;
      poll(2, 1'b1, 40, "manual to secondary");
      repeat (40) @(posedge hclk);
      chk(32'(dlt(4) >= 2), 32'h1, "lock loss two new edges");
      chk(32'(input_lost_flag), 32'h0, "secondary present");
      gp[5] <= 1'b0;
      poll(2, 1'b0, 40, "manual to primary");
      $display("done: manual");
   endtask

   task t_revert;
      repeat (60) @(posedge hclk);
      xfer(1'b1, 32'h00, 32'h00000fc3);
      s = cnt;
      run_a <= 1'b0;
      poll(2, 1'b1, 60, "revertive switch");
      chk(32'(input_lost_flag), 32'h1, "primary lost");
      repeat (30) @(posedge hclk);
      chk(32'(dlt(4) >= 2), 32'h1, "lock loss on auto switch");
      run_a <= 1'b1;
      repeat (40) @(posedge hclk);
      poll(2, 1'b1, 1, "no early return");
      poll(2, 1'b0, 60, "return after 8");
      repeat (2) @(posedge hclk);
      chk(32'(input_lost_flag), 32'h0, "input loss cleared");
      $display("done: revertive");
   endtask

   task t_nonrev;
      xfer(1'b1, 32'h00, 32'h00000fc2);
      run_a <= 1'b0;
      poll(2, 1'b1, 60, "non-revertive switch");
      run_a <= 1'b1;
      repeat (200) @(posedge hclk);
      poll(2, 1'b1, 1, "stays on secondary");
      gp[5] <= 1'b1;
      repeat (10) @(posedge hclk);
      gp[5] <= 1'b0;
      poll(2, 1'b0, 60, "select toggle returns");
      $display("done: non-revertive");
   endtask

   task t_dead;
      xfer(1'b1, 32'h00, 32'h00000fc0);
      run_a <= 1'b0;
      run_b <= 1'b0;
      repeat (80) @(posedge hclk);
      chk(32'(lock_lost), 32'h1, "both dead lock");
      chk(32'(input_lost_flag), 32'h1, "both dead input");
      run_a <= 1'b1;
      run_b <= 1'b1;
      repeat (80) @(posedge hclk);
      chk(32'(input_lost_flag), 32'h0, "input back");
      $display("done: dead inputs");
   endtask

   task t_postdiv;
      xfer(1'b1, 32'h04, 32'h00000fcf);
      xfer(1'b1, 32'h00, 32'h00003fc0);
      xfer(1'b1, 32'h24, 32'h00030002);
      xfer(1'b1, 32'h28, 32'h0);
      repeat (20) @(posedge hclk);
      s = cnt;
      repeat (640) @(posedge hclk);
      chk(32'(dlt(1) >= dlt(0) / 4 - 1 && dlt(1) <= dlt(0) / 4 + 1), 32'h1, "q1 div");
      chk(32'(dlt(2) >= dlt(3) - 1 && dlt(2) <= dlt(3) + 1), 32'h1, "bank2 from pll");
      xfer(1'b1, 32'h28, 32'h00010000);
      xfer(1'b1, 32'h08, 32'h00000001);
      repeat (20) @(posedge hclk);
      s = cnt;
      repeat (320) @(posedge hclk);
      chk(32'(dlt(3) >= 2 * dlt(2) - 2 && dlt(3) <= 2 * dlt(2) + 2), 32'h1, "q set 1");
      $display("done: post-divider");
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      gp = 6'b000110;
      run_a = 1'b1;
      run_b = 1'b1;
      pll_locked = 3'h7;
      pll_powered = 3'h7;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_defaults;
      t_config;
      t_lock;
      t_manual;
      t_revert;
      t_nonrev;
      t_dead;
      t_postdiv;
      end_sim;
   end
endmodule
